//--- core/frw_pkg.sv
// Package for the flash register write control block
`default_nettype none
package frw_pkg;
  localparam logic [7:0] OP_WRITE_REGS    = 8'h01;
  localparam logic [7:0] OP_WRITE_EN      = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS     = 8'h04;
  localparam logic [7:0] OP_VOL_WRITE_EN  = 8'h50;
  localparam logic [7:0] OP_CLEAR_STATUS  = 8'h30;
  // Status 1 bit positions
  localparam int SR1_WIP_POS   = 0;
  localparam int SR1_WEL_POS   = 1;
  localparam int SR1_SRP_POS   = 7;
  // Status 2 bit positions
  localparam int SR2_PERR_POS  = 5;
  localparam int SR2_EERR_POS  = 6;
  // Quad enable positions
  localparam int CR1_QUAD_POS  = 1;
  localparam int CR2_QPI_POS   = 3;
  // Reset values of the non-volatile copies
  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] CR1_RESET = 8'h00;
  localparam logic [7:0] CR2_RESET = 8'h00;
  localparam logic [7:0] CR3_RESET = 8'h00;
  // Self-timed write durations
  localparam int NV_WRITE_TIME_NS  = 2000;
  localparam int VOL_WRITE_TIME_NS = 50;
  localparam int CLK_PERIOD_NS     = 10;
  localparam int NV_WRITE_CYCLES   = NV_WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int VOL_WRITE_CYCLES  = VOL_WRITE_TIME_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] sr1;
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [7:0] cr3;
  } frw_regs_s;

  typedef enum logic [1:0] {
    FRW_TGT_NONE,
    FRW_TGT_NV,
    FRW_TGT_VOL
  } frw_target_e;
endpackage : frw_pkg
`default_nettype wire

//--- core/frw_ctrl.sv
// Command interpreter for register write, write enable and write disable
// What this block does
// - Opcode 01h writes status and config registers
// - Register write needs prior enable command
// - Write enable sets latch, targets non-volatile
// - Volatile enable targets volatile copies only
// - Non-volatile write erases, programs, copies volatile
// - Byte count from chip-select rise point
// - Chip-select rise starts busy write period
// - Latch clears when register write completes
// - Failure sets error, busy until clear
// - Resets ignored during register write
// - Serial or quad four-bit shifting
// - Block protect bits writable either copy
// - Protect bit zero allows enabled writes
// - Protect bit and pin low rejects silently
// - Protection any order, released by pin
// - Quad modes disable pin protection
// - Opcode 06h sets write enable latch
// - Write enable needs exact eight bits
// - Opcode 04h clears write enable latch
// - Latch zero refuses latch-gated commands
// - Write disable ignored while busy
// - Write disable needs exact eight bits
// - Opcode 50h does not set latch
// - Opcode 30h clears latch, errors, hung busy
// - Volatile status 1 always readable
`default_nettype none
module frw_ctrl
  import frw_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic [3:0] io_in,
  input  wire logic       wp_n_in,
  input  wire logic       fail_in,
  input  wire logic       hw_reset_in,
  input  wire logic       sw_reset_in,
  output logic            wip_out,
  output logic            wel_out,
  output logic            gated_ok_out,
  output logic [7:0]      status1_volatile_out,
  output logic [7:0]      status2_volatile_out,
  output frw_regs_s       vol_regs_out,
  output frw_regs_s       nv_regs_out,
  output logic            busy_reset_block_out
);

  // Two-stage synchronisers for pins
  logic [1:0] sck_sy_r, cs_sy_r, wp_sy_r, hwr_sy_r;
  logic [3:0] io_s1_r, io_s2_r;
  logic       sck_d_r, cs_d_r;
  always_ff @(posedge core_clk_in)
  begin
    sck_sy_r <= {sck_sy_r[0], sck_in};
    cs_sy_r  <= {cs_sy_r[0], cs_n_in};
    wp_sy_r  <= {wp_sy_r[0], wp_n_in};
    hwr_sy_r <= {hwr_sy_r[0], hw_reset_in};
    io_s1_r  <= io_in;
    io_s2_r  <= io_s1_r;
    sck_d_r  <= sck_sy_r[1];
    cs_d_r   <= cs_sy_r[1];
  end

  logic sck_rise, cs_rise, cs_low;
  assign sck_rise = sck_sy_r[1] & ~sck_d_r;
  assign cs_rise  = cs_sy_r[1] & ~cs_d_r;
  assign cs_low   = ~cs_sy_r[1];

  frw_regs_s   vol_r, nv_r;
  logic [7:0]  sr2_r;
  logic        wip_r, wel_r;
  frw_target_e tgt_r;
  logic [5:0]  bits_r;
  logic [7:0]  op_r;
  logic [31:0] data_r;
  logic [15:0] tmr_r;
  logic        nv_op_r, hang_r;
  frw_regs_s   pend_r;
  logic [2:0]  pend_mask_r;
  logic        hw_prot_r;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       en);
    merge_byte = en ? new_v : old_v;
  endfunction : merge_byte

  logic quad_on;
  assign quad_on = vol_r.cr1[CR1_QUAD_POS] | vol_r.cr2[CR2_QPI_POS];

  // Shift register: one or four bits per clock
  logic [5:0] step;
  logic [7:0] op_nxt;
  logic [3:0] nib;
  always_comb
  begin
    step = vol_r.cr2[CR2_QPI_POS] ? 6'd4 : 6'd1;
    nib  = vol_r.cr2[CR2_QPI_POS] ? io_s2_r : {3'b000, io_s2_r[0]};
    op_nxt = vol_r.cr2[CR2_QPI_POS] ? {op_r[3:0], nib}
                                    : {op_r[6:0], nib[0]};
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || !cs_low)
    begin
      bits_r <= 6'd0;
      op_r   <= 8'h00;
      data_r <= 32'h00000000;
    end
    else if (sck_rise && bits_r < 6'd40)
    begin
      bits_r <= bits_r + step;
      if (bits_r < 6'd8)
        op_r <= op_nxt;
      else if (vol_r.cr2[CR2_QPI_POS])
        data_r <= {data_r[27:0], nib};
      else
        data_r <= {data_r[30:0], nib[0]};
    end
  end

  // Byte count valid only at whole bytes
  // Enables {cr3, cr2, cr1}; status 1 is always written
  logic [2:0] mask_now;
  logic       len_ok;
  always_comb
  begin
    len_ok = 1'b1;
    case (bits_r)
      6'd16: mask_now = 3'b000;
      6'd24: mask_now = 3'b001;
      6'd32: mask_now = 3'b011;
      6'd40: mask_now = 3'b111;
      default:
      begin
        mask_now = 3'b000;
        len_ok   = 1'b0;
      end
    endcase
  end

  // Data bytes in arrival order; the last byte sits low in data_r
  frw_regs_s new_vals;
  logic [31:0] full;
  always_comb
  begin
    case (bits_r)
      6'd16:   full = {data_r[7:0], 24'h000000};
      6'd24:   full = {data_r[15:0], 16'h0000};
      6'd32:   full = {data_r[23:0], 8'h00};
      default: full = data_r;
    endcase
    new_vals = full;
  end

  // Pin protection latches in either order and releases on pin high
  logic prot_now;
  assign prot_now = vol_r.sr1[SR1_SRP_POS] & ~wp_sy_r[1] & ~quad_on;
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      hw_prot_r <= 1'b0;
    else
      hw_prot_r <= prot_now;
  end

  logic end_cmd, is_wrr, is_write_enable_cmd, is_volatile_write_enable_cmd, is_write_disable_cmd, is_clear_status_cmd, wrr_go;
  assign end_cmd  = cs_rise;
  assign is_wrr   = end_cmd && op_r == OP_WRITE_REGS && len_ok;
  assign is_write_enable_cmd  = end_cmd && op_r == OP_WRITE_EN
                    && bits_r == 6'd8;
  assign is_volatile_write_enable_cmd = end_cmd && op_r == OP_VOL_WRITE_EN && bits_r == 6'd8;
  assign is_write_disable_cmd  = end_cmd && op_r == OP_WRITE_DIS
                    && bits_r == 6'd8;
  assign is_clear_status_cmd  = end_cmd && op_r == OP_CLEAR_STATUS && bits_r == 6'd8;
  // Gated on a live enable, not busy, not protected
  assign wrr_go = is_wrr && !wip_r && tgt_r != FRW_TGT_NONE
                  && !hw_prot_r;

  // Busy timer and error hang
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      wip_r       <= 1'b0;
      tmr_r       <= 16'd0;
      nv_op_r     <= 1'b0;
      hang_r      <= 1'b0;
      pend_r      <= '0;
      pend_mask_r <= 3'b000;
    end
    else if (wrr_go)
    begin
      wip_r       <= 1'b1;
      nv_op_r     <= tgt_r == FRW_TGT_NV;
      tmr_r       <= (tgt_r == FRW_TGT_NV) ? 16'(NV_WRITE_CYCLES)
                                           : 16'(VOL_WRITE_CYCLES);
      pend_r      <= new_vals;
      pend_mask_r <= mask_now;
    end
    else if (is_clear_status_cmd && hang_r)
    begin
      wip_r  <= 1'b0;
      hang_r <= 1'b0;
    end
    else if (wip_r && !hang_r)
    begin
      if (tmr_r > 16'd1)
        tmr_r <= tmr_r - 16'd1;
      else if (fail_in)
        hang_r <= 1'b1;
      else
        wip_r <= 1'b0;
    end
  end

  logic done;
  assign done = wip_r && !hang_r && tmr_r <= 16'd1 && !fail_in;

  // Register copies; hw/sw resets do not touch them and only feed busy_reset_block_out
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      nv_r  <= {SR1_RESET, CR1_RESET, CR2_RESET, CR3_RESET};
      vol_r <= {SR1_RESET, CR1_RESET, CR2_RESET, CR3_RESET};
    end
    else if (done)
    begin
      if (nv_op_r)
      begin
        // Erase and program as one step, mirrored to volatile in the same cycle
        nv_r.sr1  <= pend_r.sr1;
        nv_r.cr1  <= merge_byte(nv_r.cr1, pend_r.cr1, pend_mask_r[0]);
        nv_r.cr2  <= merge_byte(nv_r.cr2, pend_r.cr2, pend_mask_r[1]);
        nv_r.cr3  <= merge_byte(nv_r.cr3, pend_r.cr3, pend_mask_r[2]);
        vol_r.sr1 <= pend_r.sr1;
        vol_r.cr1 <= merge_byte(nv_r.cr1, pend_r.cr1, pend_mask_r[0]);
        vol_r.cr2 <= merge_byte(nv_r.cr2, pend_r.cr2, pend_mask_r[1]);
        vol_r.cr3 <= merge_byte(nv_r.cr3, pend_r.cr3, pend_mask_r[2]);
      end
      else
      begin
        vol_r.sr1 <= pend_r.sr1;
        vol_r.cr1 <= merge_byte(vol_r.cr1, pend_r.cr1, pend_mask_r[0]);
        vol_r.cr2 <= merge_byte(vol_r.cr2, pend_r.cr2, pend_mask_r[1]);
        vol_r.cr3 <= merge_byte(vol_r.cr3, pend_r.cr3, pend_mask_r[2]);
      end
    end
  end

  // Write enable latch and write target
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      wel_r <= 1'b0;
      tgt_r <= FRW_TGT_NONE;
    end
    else if (done || is_clear_status_cmd)
    begin
      wel_r <= 1'b0;
      tgt_r <= FRW_TGT_NONE;
    end
    else if (wrr_go)
      tgt_r <= FRW_TGT_NONE;
    else if (is_write_enable_cmd && !wip_r)
    begin
      wel_r <= 1'b1;
      tgt_r <= FRW_TGT_NV;
    end
    else if (is_volatile_write_enable_cmd && !wip_r)
      tgt_r <= FRW_TGT_VOL;
    else if (is_write_disable_cmd && !wip_r)
    begin
      wel_r <= 1'b0;
      tgt_r <= FRW_TGT_NONE;
    end
  end

  // Error flags: failure set wins over a same-cycle clear
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      sr2_r <= 8'h00;
    else if (wip_r && !hang_r && tmr_r <= 16'd1 && fail_in)
    begin
      if (nv_op_r)
        sr2_r[SR2_EERR_POS] <= 1'b1;
      else
        sr2_r[SR2_PERR_POS] <= 1'b1;
    end
    else if (is_clear_status_cmd)
    begin
      sr2_r[SR2_PERR_POS] <= 1'b0;
      sr2_r[SR2_EERR_POS] <= 1'b0;
    end
  end

  // Outputs from flip-flops
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      wip_out              <= 1'b0;
      wel_out              <= 1'b0;
      gated_ok_out         <= 1'b0;
      status1_volatile_out <= 8'h00;
      status2_volatile_out <= 8'h00;
      vol_regs_out         <= '0;
      nv_regs_out          <= '0;
      busy_reset_block_out <= 1'b0;
    end
    else
    begin
      wip_out      <= wip_r;
      wel_out      <= wel_r;
      gated_ok_out <= wel_r;
      status1_volatile_out <= {vol_r.sr1[7:2], wel_r, wip_r};
      status2_volatile_out <= sr2_r;
      vol_regs_out <= vol_r;
      nv_regs_out  <= nv_r;
      busy_reset_block_out <= wip_r & (hwr_sy_r[1] | sw_reset_in);
    end
  end

  wrr_busy_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    wrr_go |=> wip_r) else $error("write not busy");
  rej_idle_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (is_wrr && hw_prot_r && !wip_r) |=> !wip_r)
    else $error("rejected write went busy");
  wel_done_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    done |=> !wel_r) else $error("latch not cleared");
  write_enable_cmd_set_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (is_write_enable_cmd && !wip_r && !done) |=> wel_r)
    else $error("enable not set");
  write_disable_cmd_busy_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (is_write_disable_cmd && wip_r && wel_r && !done && !is_clear_status_cmd) |=> wel_r)
    else $error("disable acted while busy");
  volatile_write_enable_cmd_nowel_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (is_volatile_write_enable_cmd && !wel_r) |=> !wel_r)
    else $error("volatile enable set latch");
  hang_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (hang_r && !is_clear_status_cmd) |=> (wip_r && hang_r))
    else $error("hang released");
  no_enable_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (is_wrr && tgt_r == FRW_TGT_NONE && !wip_r) |=> !wip_r)
    else $error("unenabled write ran");
  quad_prot_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $past(quad_on) |-> !hw_prot_r)
    else $error("pin protection in quad");
  nv_write_c: cover property (@(posedge core_clk_in)
    wrr_go && tgt_r == FRW_TGT_NV);
  vol_write_c: cover property (@(posedge core_clk_in)
    wrr_go && tgt_r == FRW_TGT_VOL);
  hang_c: cover property (@(posedge core_clk_in) hang_r && is_clear_status_cmd);
  reject_c: cover property (@(posedge core_clk_in) is_wrr && hw_prot_r);
endmodule : frw_ctrl
`default_nettype wire

//--- tb/frw_host_model.sv
// Host controller model that drives the serial flash command pins
`default_nettype none
module frw_host_model
(
  input  wire logic       core_clk_in,
  output logic            sck_out,
  output logic            cs_n_out,
  output logic [3:0]      io_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    io_out   = 4'h0;
  end

  // Bits are left aligned; the caller picks the count, so bad ends can be made
  task automatic xfer(input logic [39:0] bits, input int nbits,
                      input bit quad);
    int i;
    @(negedge core_clk_in);
    cs_n_out = 1'b0;
    i = 0;
    while (i < nbits)
    begin
      if (quad)
        io_out = bits[39 - i -: 4];
      else
        io_out = {~io_out[3:1], bits[39 - i]};
      // Serial low phase alternates 6 and 7 cycles for a 125 ns average period; quad low phase is always 6
      repeat (6 + (i % 2)) @(negedge core_clk_in);
      sck_out = 1'b1;
      repeat (6) @(negedge core_clk_in);
      sck_out = 1'b0;
      i = i + (quad ? 4 : 1);
    end
    cs_n_out = 1'b1;
    // Released lines must not keep the last value
    io_out = ~io_out;
    repeat (8) @(negedge core_clk_in);
  endtask : xfer
endmodule : frw_host_model
`default_nettype wire

//--- tb/frw_testbench.sv
// Self-checking testbench for the register write control block
`default_nettype none
module testbench
  import frw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk;
  logic       rst;
  logic       sck;
  logic       cs_n;
  logic [3:0] io;
  logic       wp_n;
  logic       fail;
  logic       hw_rst;
  logic       sw_rst;
  logic       write_in_progress;
  logic       write_enable_latch;
  logic       gated_ok;
  logic [7:0] s1;
  logic [7:0] s2;
  frw_regs_s  vregs;
  frw_regs_s  nregs;
  logic       blk;
  int         n_mismatch;
  int         comparisons;

  frw_host_model u_host (.core_clk_in(clk), .sck_out(sck), .cs_n_out(cs_n),
                         .io_out(io));

  frw_ctrl u_dut (.core_clk_in(clk), .rst_in(rst), .sck_in(sck),
    .cs_n_in(cs_n), .io_in(io), .wp_n_in(wp_n), .fail_in(fail),
    .hw_reset_in(hw_rst), .sw_reset_in(sw_rst), .wip_out(write_in_progress),
    .wel_out(write_enable_latch), .gated_ok_out(gated_ok), .status1_volatile_out(s1),
    .status2_volatile_out(s2), .vol_regs_out(vregs), .nv_regs_out(nregs),
    .busy_reset_block_out(blk));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] op, input bit q);
    u_host.xfer({op, 32'h0}, 8, q);
  endtask : cmd

  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (write_in_progress !== 1'b0 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk("wip_idle", 1'b0, write_in_progress);
  endtask : wait_idle

  task automatic t_nv();
    cmd(OP_WRITE_EN, 0);
    chk("wel", 1'b1, write_enable_latch);
    chk("gated_ok", 1'b1, gated_ok);
    u_host.xfer({OP_WRITE_REGS, 8'h1c, 24'h0}, 16, 0);
    chk("wip_busy", 1'b1, write_in_progress);
    repeat (150) @(negedge clk);
    chk("wip_hold", 1'b1, write_in_progress);
    wait_idle(300);
    chk("nv_regs", 32'h1c000000, nregs);
    chk("vol_regs", 32'h1c000000, vregs);
    chk("status1", 8'h1c, s1);
  endtask : t_nv

  task automatic t_vol();
    cmd(OP_VOL_WRITE_EN, 0);
    chk("wel_vol", 1'b0, write_enable_latch);
    u_host.xfer({OP_WRITE_REGS, 32'h08000055}, 40, 0);
    wait_idle(20);
    chk("vol_regs", 32'h08000055, vregs);
    chk("nv_keep", 32'h1c000000, nregs);
  endtask : t_vol

  task automatic t_refuse();
    u_host.xfer({OP_WRITE_REGS, 8'h00, 24'h0}, 16, 0);
    chk("wip_none", 1'b0, write_in_progress);
    chk("vol_keep", 32'h08000055, vregs);
    cmd(OP_WRITE_EN, 0);
    u_host.xfer({OP_WRITE_DIS, 32'h0}, 9, 0);
    chk("wel_keep", 1'b1, write_enable_latch);
    u_host.xfer({OP_WRITE_REGS, 8'h00, 24'h0}, 20, 0);
    chk("wip_abort", 1'b0, write_in_progress);
    chk("vol_abort", 32'h08000055, vregs);
    cmd(OP_WRITE_DIS, 0);
    chk("wel_clear", 1'b0, write_enable_latch);
    chk("gated_off", 1'b0, gated_ok);
    u_host.xfer({OP_WRITE_EN, 32'h0}, 7, 0);
    chk("wel_short", 1'b0, write_enable_latch);
  endtask : t_refuse

  task automatic t_protect();
    wp_n = 1'b0;
    cmd(OP_VOL_WRITE_EN, 0);
    u_host.xfer({OP_WRITE_REGS, 8'h80, 24'h0}, 16, 0);
    wait_idle(20);
    chk("vol_sp0", 32'h80000055, vregs);
    cmd(OP_WRITE_EN, 0);
    u_host.xfer({OP_WRITE_REGS, 8'h84, 24'h0}, 16, 0);
    chk("wip_prot", 1'b0, write_in_progress);
    chk("vol_prot", 32'h80000055, vregs);
    chk("no_error", 8'h00, s2);
    cmd(OP_WRITE_DIS, 0);
    wp_n = 1'b1;
    cmd(OP_VOL_WRITE_EN, 0);
    u_host.xfer({OP_WRITE_REGS, 16'h8002, 16'h0}, 24, 0);
    wait_idle(20);
    chk("vol_release", 32'h80020055, vregs);
    wp_n = 1'b0;
    cmd(OP_VOL_WRITE_EN, 0);
    u_host.xfer({OP_WRITE_REGS, 32'h0}, 24, 0);
    wait_idle(20);
    chk("vol_quad", 32'h00000055, vregs);
  endtask : t_protect

  task automatic t_fail();
    fail = 1'b1;
    cmd(OP_WRITE_EN, 0);
    u_host.xfer({OP_WRITE_REGS, 8'h0c, 24'h0}, 16, 0);
    repeat (400) @(negedge clk);
    chk("wip_hang", 1'b1, write_in_progress);
    chk("erase_err", 1'b1, s2[SR2_EERR_POS]);
    cmd(OP_WRITE_DIS, 0);
    chk("wel_busy", 1'b1, write_enable_latch);
    hw_rst = 1'b1;
    sw_rst = 1'b1;
    repeat (4) @(negedge clk);
    hw_rst = 1'b0;
    sw_rst = 1'b0;
    chk("reset_block", 1'b1, blk);
    chk("wip_reset", 1'b1, write_in_progress);
    cmd(OP_CLEAR_STATUS, 0);
    fail = 1'b0;
    chk("wip_clear_status_cmd", 1'b0, write_in_progress);
    chk("wel_clear_status_cmd", 1'b0, write_enable_latch);
    chk("s2_clear_status_cmd", 8'h00, s2);
    fail = 1'b1;
    cmd(OP_VOL_WRITE_EN, 0);
    u_host.xfer({OP_WRITE_REGS, 8'h3c, 24'h0}, 16, 0);
    repeat (30) @(negedge clk);
    chk("wip_vhang", 1'b1, write_in_progress);
    chk("prog_err", 1'b1, s2[SR2_PERR_POS]);
    chk("vol_fail", 32'h00000055, vregs);
    cmd(OP_CLEAR_STATUS, 0);
    fail = 1'b0;
    chk("s2_vclr", 8'h00, s2);
    wait_idle(20);
  endtask : t_fail

  task automatic t_qpi();
    // Reserved bits are always sent as zero
    cmd(OP_VOL_WRITE_EN, 0);
    u_host.xfer({OP_WRITE_REGS, 32'h00000800}, 40, 0);
    wait_idle(20);
    chk("vol_qpi", 32'h00000800, vregs);
    cmd(OP_WRITE_EN, 1);
    chk("wel_qpi", 1'b1, write_enable_latch);
    cmd(OP_WRITE_DIS, 1);
    chk("wel_qpi_off", 1'b0, write_enable_latch);
    cmd(OP_VOL_WRITE_EN, 1);
    u_host.xfer({OP_WRITE_REGS, 32'h0}, 32, 1);
    wait_idle(20);
    chk("vol_exit", 32'h00000000, vregs);
  endtask : t_qpi

  initial
  begin
    n_mismatch  = 0;
    comparisons = 0;
    rst    = 1'b1;
    wp_n   = 1'b1;
    fail   = 1'b0;
    hw_rst = 1'b0;
    sw_rst = 1'b0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    chk("wel_reset", 1'b0, write_enable_latch);
    t_nv();
    t_vol();
    t_refuse();
    t_protect();
    t_fail();
    t_qpi();
    finish_test();
  end

  // Whole run needs well under half of this span
  initial
  begin
    #800us;
    n_mismatch++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
